// ---- hw/bbar_pkg.sv ----
package bbar_pkg;

  localparam logic [31:0] BBAR_ADDR_BUF0_START = 32'h0FFFFF0C;
  localparam logic [31:0] BBAR_ADDR_BUF1_START = 32'hFFFFFF1C;
  localparam logic [31:0] BBAR_ADDR_BUF0_PTR   = 32'h0FFFFF2C;
  localparam logic [31:0] BBAR_ADDR_BUF1_PTR   = 32'h0FFFFF3C;
  localparam logic [31:0] BBAR_ADDR_PM_START   = 32'h0FFFFF6C;
  localparam logic [31:0] BBAR_ADDR_POWER_MGMT_WINDOW_MASK    = 32'hFFFFFF7C;

  localparam int BBAR_IDX_MSB  = 11;
  localparam int BBAR_IDX_LSB  = 4;
  localparam int BBAR_BYTE_MSB = 3;
  localparam int BBAR_BYTE_LSB = 0;
  localparam int BBAR_SPAD_MSB = 3;
  localparam int BBAR_SPAD_LSB = 2;

  localparam logic [15:0] BBAR_OP_REWIND0 = 16'h0F3A;
  localparam logic [15:0] BBAR_OP_REWIND1 = 16'h0F3B;
  localparam logic [15:0] BBAR_OP_WRITE   = 16'h0F3C;
  localparam logic [15:0] BBAR_OP_READ    = 16'h0F3D;

  localparam logic [31:0] BBAR_IO_HIGH_BIT = 32'h80000000;

  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [31:0] general_base_reg;
    logic [31:0] accumulator_reg;
  } bbar_instr_t;

  typedef struct packed {
    logic        valid;
    logic        illegal_op;
    logic        rd_valid;
    logic [31:0] accumulator_reg;
  } bbar_result_t;

  typedef struct packed {
    logic        req;
    logic        buf_sel;
    logic        done;
  } bbar_blit_req_t;

endpackage

// ---- hw/bbar_regs.sv ----
`timescale 1ns/1ps
module bbar_regs (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [31:0]            global_config_reg,
  input  wire bbar_pkg::bbar_instr_t  instr,
  output bbar_pkg::bbar_result_t      result,
  output logic                        io_valid,
  output logic [31:0]                 io_addr,
  output logic                        io_write,
  output logic [31:0]                 io_data,
  output logic [1:0]                  mem_map_base,
  input  wire bbar_pkg::bbar_blit_req_t blit,
  output logic                        spad_valid,
  output logic [11:0]                 spad_addr
);
  import bbar_pkg::*;

  logic [15:0] buf_start [2];
  logic [7:0]  buf_line  [2];
  logic [31:0] pm_start;
  logic [31:0] power_mgmt_window_mask;

  // Memory map base passes straight through, independent of enable
  assign mem_map_base = global_config_reg[1:0];

  wire gfx_enabled = global_config_reg[BBAR_SPAD_MSB:BBAR_SPAD_LSB] != 2'b00;

  wire is_rw0 = instr.opcode == BBAR_OP_REWIND0;
  wire is_rw1 = instr.opcode == BBAR_OP_REWIND1;
  wire is_wr  = instr.opcode == BBAR_OP_WRITE;
  wire is_rd  = instr.opcode == BBAR_OP_READ;
  wire is_gfx = is_rw0 | is_rw1 | is_wr | is_rd;

  wire exec    = instr.valid & is_gfx & gfx_enabled;
  wire trap    = instr.valid & is_gfx & ~gfx_enabled;
  wire do_wr   = exec & is_wr;
  wire do_rd   = exec & is_rd;
  wire rewind0 = exec & is_rw0;
  wire rewind1 = exec & is_rw1;

  wire [31:0] reg_addr = instr.general_base_reg;
  wire [31:0] wdata    = instr.accumulator_reg;

  wire sel_s0 = reg_addr == BBAR_ADDR_BUF0_START;
  wire sel_s1 = reg_addr == BBAR_ADDR_BUF1_START;
  wire sel_p0 = reg_addr == BBAR_ADDR_BUF0_PTR;
  wire sel_p1 = reg_addr == BBAR_ADDR_BUF1_PTR;
  wire sel_pb = reg_addr == BBAR_ADDR_PM_START;
  wire sel_pm = reg_addr == BBAR_ADDR_POWER_MGMT_WINDOW_MASK;

  // Reserved bits forced to zero on store
  wire [15:0] start_wval = {4'h0, wdata[BBAR_IDX_MSB:BBAR_BYTE_LSB]};
  wire [7:0]  line_wval  = wdata[BBAR_IDX_MSB:BBAR_IDX_LSB];

  wire [31:0] rd_mux =
      sel_s0 ? {16'h0000, buf_start[0]} :
      sel_s1 ? {16'h0000, buf_start[1]} :
      sel_p0 ? {20'h00000, buf_line[0], 4'h0} :
      sel_p1 ? {20'h00000, buf_line[1], 4'h0} :
      sel_pb ? pm_start :
      sel_pm ? power_mgmt_window_mask : 32'h00000000;

  // Blit translation: line index plus start byte
  wire       bsel     = blit.buf_sel;
  wire [7:0] cur_line = buf_line[bsel];
  wire [3:0] cur_byte = buf_start[bsel][BBAR_BYTE_MSB:BBAR_BYTE_LSB];

  // Per-buffer pointer events; blit done and rewind both reload from start
  wire adv0 = blit.req & ~bsel;
  wire adv1 = blit.req & bsel;
  wire rld0 = (blit.done & ~bsel) | rewind0;
  wire rld1 = (blit.done & bsel) | rewind1;
  wire swr0 = do_wr & sel_p0;
  wire swr1 = do_wr & sel_p1;

  // Everything it reads comes in as an argument, so the nets track all inputs
  // Priority, lowest first: advance, reload, software write
  function automatic logic [7:0] next_line_f(input logic [7:0] cur,
                                             input logic [7:0] start_idx,
                                             input logic       adv,
                                             input logic       rld,
                                             input logic       swr,
                                             input logic [7:0] sw_val);
    logic [7:0] v;
    v = cur;
    if (adv) begin
      v = cur + 8'h01;
    end
    if (rld) begin
      v = start_idx;
    end
    if (swr) begin
      v = sw_val;
    end
    return v;
  endfunction

  wire [7:0] next_line0 = next_line_f(buf_line[0], buf_start[0][BBAR_IDX_MSB:BBAR_IDX_LSB],
                                      adv0, rld0, swr0, line_wval);
  wire [7:0] next_line1 = next_line_f(buf_line[1], buf_start[1][BBAR_IDX_MSB:BBAR_IDX_LSB],
                                      adv1, rld1, swr1, line_wval);

  // Storage registers have no reset value; software loads them
  always_ff @(posedge clk) begin
    if (do_wr && sel_s0) begin
      buf_start[0] <= start_wval;
    end
    if (do_wr && sel_s1) begin
      buf_start[1] <= start_wval;
    end
    if (do_wr && sel_pb) begin
      pm_start <= wdata;
    end
    if (do_wr && sel_pm) begin
      power_mgmt_window_mask <= wdata;
    end
    buf_line[0] <= next_line0;
    buf_line[1] <= next_line1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result     <= '0;
      io_valid   <= 1'b0;
      io_addr    <= 32'h00000000;
      io_write   <= 1'b0;
      io_data    <= 32'h00000000;
      spad_valid <= 1'b0;
      spad_addr  <= 12'h000;
    end else begin
      result.valid           <= instr.valid & is_gfx;
      result.illegal_op      <= trap;
      result.rd_valid        <= do_rd;
      result.accumulator_reg <= do_rd ? rd_mux : 32'h00000000;
      io_valid               <= do_wr | do_rd;
      io_addr                <= reg_addr | BBAR_IO_HIGH_BIT;
      io_write               <= do_wr;
      io_data                <= do_wr ? wdata : 32'h00000000;
      spad_valid             <= blit.req;
      spad_addr              <= {cur_line, cur_byte};
    end
  end

  // Read-back steps: a store, one cycle without a store there, then a read
  sequence s_pm_start_wr;
    do_wr && sel_pb;
  endsequence

  sequence s_pm_start_rd_gap;
    !(do_wr && sel_pb) ##1 (do_rd && sel_pb);
  endsequence

  sequence s_power_mgmt_window_mask_wr;
    do_wr && sel_pm;
  endsequence

  sequence s_power_mgmt_window_mask_rd_gap;
    !(do_wr && sel_pm) ##1 (do_rd && sel_pm);
  endsequence

  sequence s_start0_wr;
    do_wr && sel_s0;
  endsequence

  sequence s_start0_rd_gap;
    !(do_wr && sel_s0) ##1 (do_rd && sel_s0);
  endsequence

  // A lone advance, with no reload or executed opcode in the same cycle
  sequence s_buf0_adv_only;
    blit.req && !blit.done && !exec && !blit.buf_sel;
  endsequence

  sequence s_buf1_adv_only;
    blit.req && !blit.done && !exec && blit.buf_sel;
  endsequence

  a_trap_when_off: assert property (@(posedge clk) disable iff (!rst_n)
    instr.valid && is_gfx && global_config_reg[3:2] == 2'h0 |=>
    result.illegal_op && !io_valid)
    else $error("graphics opcode not trapped while disabled");

  a_no_trap_on: assert property (@(posedge clk) disable iff (!rst_n)
    instr.valid && global_config_reg[3:2] != 2'h0 |=> !result.illegal_op)
    else $error("trap raised while enabled");

  a_trap_no_store: assert property (@(posedge clk) disable iff (!rst_n)
    trap && sel_s0 |=> buf_start[0] == $past(buf_start[0]))
    else $error("trapped opcode changed a start register");

  a_trap_no_rewind: assert property (@(posedge clk) disable iff (!rst_n)
    trap && is_rw0 |=> buf_line[0] == $past(buf_line[0]))
    else $error("trapped rewind moved the pointer");

  a_io_high_bit: assert property (@(posedge clk) disable iff (!rst_n)
    io_valid |-> io_addr[31] && io_addr[30:0] == $past(instr.general_base_reg[30:0]))
    else $error("io address wrong or top bit clear");

  a_wr_io: assert property (@(posedge clk) disable iff (!rst_n)
    do_wr |=> io_valid && io_write && io_data == $past(wdata))
    else $error("write did not issue io with accumulator data");

  a_rd_io: assert property (@(posedge clk) disable iff (!rst_n)
    do_rd |=> io_valid && !io_write && result.rd_valid)
    else $error("read did not issue io read");

  a_rewind_no_io: assert property (@(posedge clk) disable iff (!rst_n)
    rewind0 || rewind1 |=> result.valid && !io_valid && !result.illegal_op)
    else $error("rewind issued io or trapped");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !instr.valid |=> !result.valid && !io_valid && !result.rd_valid)
    else $error("result or io raised without an opcode");

  a_write_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    s_pm_start_wr ##1 s_pm_start_rd_gap |=> result.accumulator_reg == $past(wdata, 3))
    else $error("power window start read back mismatch");

  a_mask_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    s_power_mgmt_window_mask_wr ##1 s_power_mgmt_window_mask_rd_gap |=> result.accumulator_reg == $past(wdata, 3))
    else $error("power window mask read back mismatch");

  a_start0_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    s_start0_wr ##1 s_start0_rd_gap |=>
    result.accumulator_reg == {20'h00000, $past(wdata[11:0], 3)})
    else $error("buffer 0 start read back mismatch");

  a_start0_store: assert property (@(posedge clk) disable iff (!rst_n)
    do_wr && sel_s0 |=> buf_start[0] == {4'h0, $past(wdata[11:0])})
    else $error("buffer 0 start stored wrong");

  a_start1_store: assert property (@(posedge clk) disable iff (!rst_n)
    do_wr && sel_s1 |=> buf_start[1] == {4'h0, $past(wdata[11:0])})
    else $error("buffer 1 start stored wrong");

  a_ptr0_store: assert property (@(posedge clk) disable iff (!rst_n)
    do_wr && sel_p0 |=> buf_line[0] == $past(wdata[11:4]))
    else $error("buffer 0 pointer stored wrong");

  a_ptr1_store: assert property (@(posedge clk) disable iff (!rst_n)
    do_wr && sel_p1 |=> buf_line[1] == $past(wdata[11:4]))
    else $error("buffer 1 pointer stored wrong");

  a_ptr0_read: assert property (@(posedge clk) disable iff (!rst_n)
    do_rd && sel_p0 |=> result.accumulator_reg[11:4] == $past(buf_line[0]))
    else $error("buffer 0 pointer read wrong");

  a_start_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_rd && (sel_s0 || sel_s1) |=> result.accumulator_reg[31:12] == 20'h00000)
    else $error("start register reserved bits nonzero");

  a_ptr_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_rd && (sel_p0 || sel_p1) |=> result.accumulator_reg[3:0] == 4'h0
    && result.accumulator_reg[31:12] == 20'h00000)
    else $error("pointer register reserved bits nonzero");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_rd && !(sel_s0 || sel_s1 || sel_p0 || sel_p1 || sel_pb || sel_pm) |=>
    result.accumulator_reg == 32'h00000000)
    else $error("unmapped read returned nonzero");

  a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n)
    s_buf0_adv_only |=> buf_line[0] == $past(buf_line[0]) + 8'h01)
    else $error("pointer did not advance");

  a_ptr1_advance: assert property (@(posedge clk) disable iff (!rst_n)
    s_buf1_adv_only |=> buf_line[1] == $past(buf_line[1]) + 8'h01)
    else $error("buffer 1 pointer did not advance");

  a_line_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    blit.req && !blit.done && !exec && !blit.buf_sel && buf_line[0] == 8'hFF |=>
    buf_line[0] == 8'h00)
    else $error("pointer did not wrap to line zero");

  a_rewind_reload: assert property (@(posedge clk) disable iff (!rst_n)
    rewind0 && !(do_wr) |=> buf_line[0] == $past(buf_start[0][11:4]))
    else $error("rewind did not reload pointer");

  a_rewind1_reload: assert property (@(posedge clk) disable iff (!rst_n)
    rewind1 |=> buf_line[1] == $past(buf_start[1][11:4]))
    else $error("buffer 1 rewind did not reload pointer");

  a_done_reload: assert property (@(posedge clk) disable iff (!rst_n)
    blit.done && blit.buf_sel && !exec |=> buf_line[1] == $past(buf_start[1][11:4]))
    else $error("blit done did not reload pointer");

  a_done0_reload: assert property (@(posedge clk) disable iff (!rst_n)
    blit.done && !blit.buf_sel && !exec |=> buf_line[0] == $past(buf_start[0][11:4]))
    else $error("blit done did not reload buffer 0 pointer");

  a_spad_addr: assert property (@(posedge clk) disable iff (!rst_n)
    blit.req |=> spad_valid && spad_addr == {$past(cur_line), $past(cur_byte)})
    else $error("scratchpad address wrong");

  a_spad_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !blit.req |=> !spad_valid)
    else $error("scratchpad access without a request");

endmodule

// ---- tb/bbar_core_model.sv ----
`timescale 1ns/1ps
module bbar_core_model (
  input  wire logic                clk,
  output bbar_pkg::bbar_instr_t    instr,
  output bbar_pkg::bbar_blit_req_t blit
);
  import bbar_pkg::*;
  initial begin
    instr = '0;
    blit  = '0;
  end
  // Fields scramble once the request is gone
  task automatic op(input logic [15:0] code, input logic [31:0] addr, input logic [31:0] data);
    @(negedge clk);
    instr <= '{1'b1, code, addr, data};
    @(negedge clk);
    instr <= '{1'b0, ~code, ~addr, ~data};
  endtask
  // Callers load both registers with scratchpad enabled first
  task automatic pipe(input logic sel, input logic done);
    @(negedge clk);
    blit <= '{~done, sel, done};
    @(negedge clk);
    blit <= '{1'b0, ~sel, 1'b0};
  endtask
endmodule

// ---- tb/bbar_regs_test.sv ----
`timescale 1ns/1ps
module bbar_regs_test;
  import bbar_pkg::*;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [31:0]    global_config_reg = 32'h00000005;
  bbar_instr_t    instr;
  bbar_blit_req_t blit;
  bbar_result_t   result;
  logic           io_valid, io_write, spad_valid;
  logic [31:0]    io_addr, io_data;
  logic [1:0]     mem_map_base;
  logic [11:0]    spad_addr;
  int             n_errors = 0;
  int             comparisons = 0;
  int             cycles = 0;

  bbar_regs u_bbar_regs (.clk, .rst_n, .global_config_reg, .instr, .result, .io_valid,
    .io_addr, .io_write, .io_data, .mem_map_base, .blit, .spad_valid, .spad_addr);
  bbar_core_model u_bbar_core_model (.clk, .instr, .blit);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    u_bbar_core_model.op(BBAR_OP_READ, addr, 32'h00000000);
    chk("rd_flags", 32'({io_valid, io_write, result.rd_valid}), 32'h00000005);
    chk("rd_addr", io_addr, addr | BBAR_IO_HIGH_BIT);
    chk("rd_data", result.accumulator_reg, exp);
  endtask

  task automatic wr_rd(input logic [31:0] addr, input logic [31:0] data, input logic [31:0] exp);
    u_bbar_core_model.op(BBAR_OP_WRITE, addr, data);
    chk("io_addr", io_addr, addr | BBAR_IO_HIGH_BIT);
    chk("io_data", io_data, data);
    chk("wr_flags", 32'({io_valid, io_write, result.valid}), 32'h00000007);
    rd_chk(addr, exp);
  endtask

  task automatic spad(input logic sel, input logic done, input logic [31:0] exp);
    u_bbar_core_model.pipe(sel, done);
    chk("spad", 32'({spad_valid, spad_addr}), exp);
  endtask

  task automatic t_regs();
    wr_rd(BBAR_ADDR_BUF0_START, 32'hFFFFF5A7, 32'h000005A7);
    wr_rd(BBAR_ADDR_BUF1_START, 32'h00000C3E, 32'h00000C3E);
    wr_rd(BBAR_ADDR_BUF0_PTR, 32'h0000F7B9, 32'h000007B0);
    wr_rd(BBAR_ADDR_BUF1_PTR, 32'h00000A5F, 32'h00000A50);
    wr_rd(BBAR_ADDR_PM_START, 32'hDEADBEEF, 32'hDEADBEEF);
    wr_rd(BBAR_ADDR_POWER_MGMT_WINDOW_MASK, 32'h12345678, 32'h12345678);
    wr_rd(32'h0FFFFF4C, 32'h0000ABCD, 32'h00000000);
  endtask

  task automatic t_blit();
    wr_rd(BBAR_ADDR_BUF0_START, 32'h00000FE3, 32'h00000FE3);
    u_bbar_core_model.op(BBAR_OP_REWIND0, 32'h00000000, 32'h00000000);
    chk("rew_flags", 32'({result.valid, result.illegal_op, io_valid}), 32'h00000004);
    spad(1'b0, 1'b0, 32'h00001FE3);
    spad(1'b0, 1'b0, 32'h00001FF3);
    spad(1'b0, 1'b0, 32'h00001003);
    spad(1'b0, 1'b1, 32'h00000013);
    spad(1'b0, 1'b0, 32'h00001FE3);
    u_bbar_core_model.op(BBAR_OP_REWIND1, 32'h00000000, 32'h00000000);
    spad(1'b1, 1'b0, 32'h00001C3E);
    rd_chk(BBAR_ADDR_BUF1_PTR, 32'h00000C40);
    spad(1'b1, 1'b1, 32'h00000C4E);
    spad(1'b1, 1'b0, 32'h00001C3E);
    wr_rd(BBAR_ADDR_BUF0_PTR, 32'h00000000, 32'h00000000);
    wr_rd(BBAR_ADDR_BUF1_PTR, 32'h00000000, 32'h00000000);
    wr_rd(BBAR_ADDR_BUF0_PTR, 32'h00000FF0, 32'h00000FF0);
  endtask

  task automatic t_disabled();
    global_config_reg = 32'h00000002;
    @(negedge clk);
    chk("map_base", 32'(mem_map_base), 32'h00000002);
    for (int i = 0; i < 4; i++) begin
      u_bbar_core_model.op(BBAR_OP_REWIND0 + 16'(i), BBAR_ADDR_BUF0_START, 32'h00000111);
      chk("trap", 32'({result.valid, result.illegal_op, io_valid}), 32'h00000006);
    end
    global_config_reg = 32'h0000000D;
    wr_rd(BBAR_ADDR_POWER_MGMT_WINDOW_MASK, 32'h0000FFFF, 32'h0000FFFF);
    wr_rd(BBAR_ADDR_BUF0_PTR, 32'h00000000, 32'h00000000);
    spad(1'b0, 1'b0, 32'h00001003);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_blit();
    t_disabled();
    end_of_test();
  end
endmodule
